/* File: inc/cltpt_defs.svh */
// register offsets, field positions and reset values of the cascaded pulse timer
// assumes inclusion by bare name from the design module, the checker and the bench
`ifndef CLTPT_DEFS_SVH
`define CLTPT_DEFS_SVH
// register addresses (28-bit plain port)
`define CLTPT_ADDR_RUN 28'h00f_ffbc
`define CLTPT_ADDR_PFS9 28'h0ff_fbc9
`define CLTPT_ADDR_HALT 28'h0ff_fdc8
`define CLTPT_ADDR_CCR4 28'h0ff_fee0
`define CLTPT_ADDR_MODE4 28'h0ff_fee1
`define CLTPT_ADDR_OCR4 28'h0ff_fee2
`define CLTPT_ADDR_CNT4 28'h0ff_fee6
`define CLTPT_ADDR_CMPA4 28'h0ff_fee8
`define CLTPT_ADDR_CMPB4 28'h0ff_feea
`define CLTPT_ADDR_CCR5 28'hfff_fff0
`define CLTPT_ADDR_CNT5 28'h0ff_fef6
// field encodings
`define CLTPT_CLR_NONE 3'h0
`define CLTPT_CLR_CMPB 3'h2
`define CLTPT_PSC_DIRECT 3'h0
`define CLTPT_PSC_CASCADE 3'h7
`define CLTPT_EDGE_FALL 2'h0
`define CLTPT_MODE_PWM1 4'h2
`define CLTPT_IOB_LOW 4'h5
`define CLTPT_IOA_HIGH 4'h2
// field positions within the control registers
`define CLTPT_CLR_HI 7
`define CLTPT_CLR_LO 5
`define CLTPT_EDGE_HI 4
`define CLTPT_EDGE_LO 3
`define CLTPT_PSC_HI 2
`define CLTPT_PSC_LO 0
`define CLTPT_MODE_HI 3
`define CLTPT_MODE_LO 0
`define CLTPT_IOB_HI 7
`define CLTPT_IOB_LO 4
`define CLTPT_IOA_HI 3
`define CLTPT_IOA_LO 0
`define CLTPT_RUN_HI 5
`define CLTPT_RUN_LO 0
// bit positions
`define CLTPT_BIT_RUN4 4
`define CLTPT_BIT_RUN5 5
`define CLTPT_BIT_HALT 0
`define CLTPT_BIT_ROUTE 6
// reset values
`define CLTPT_RST_HALT 16'h0001
`define CLTPT_RST_8 8'h00
`define CLTPT_RST_16 16'h0000
`define CLTPT_CNT_MAX 16'hffff
`endif

/* File: inc/cltpt_pkg.sv */
// types for the cascaded pulse timer
// uses nothing from cltpt_defs.svh
package cltpt_pkg;
  // output pin level state
  typedef enum logic [1:0] {
    CLTPT_PIN_LOW = 2'b01,
    CLTPT_PIN_HIGH = 2'b10
  } cltpt_pin_t;
endpackage

/* File: logic/cltpt_timer.sv */
// cascaded two-channel long-period pulse timer with register port
// assumes a single 20 MHz clock and a synchronous plain register master
`timescale 1ns/1ns
`include "cltpt_defs.svh"

// Function
// - halt bit 1 stops, 0 runs module
// - halt register bit 0 gates timer unit
// - route bit moves capture input pin
// - ch4 clear field 010 clears on B
// - ch5 clear field 000 never clears
// - edge field 00 counts falling edge
// - ch4 prescaler 111 counts ch5 overflows
// - ch5 prescaler 000 uses module clock
// - mode 0010 selects PWM mode one
// - B field 0101 drives pin low
// - A field 0010 starts low, match high
// - counters are 16-bit read/write
// - start bits gate each channel counter
// - counters reset zero, 16-bit only
// - initial level applied while stopped
// - compare registers 16-bit read/write
module cltpt_timer
  import cltpt_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [27:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic regWide,
  output logic [15:0] regRdData_r,
  // pins
  input wire logic capturePortPin,
  input wire logic comparePortPinIn,
  output logic comparePortPin_r,
  output logic comparePortPinOe_n_r,
  output logic captureSel_r
);

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] runCtl_r;
  logic [7:0] pinSel_r;
  logic [15:0] haltCtl_r;
  logic [7:0] ccr4_r;
  logic [7:0] mode4_r;
  logic [7:0] ocr4_r;
  logic [7:0] ccr5_r;
  logic [15:0] cmpA4_r;
  logic [15:0] cmpB4_r;
  logic [15:0] cnt4_r;
  logic [15:0] cnt5_r;
  logic [15:0] cnt4_nxt;
  logic [15:0] cnt5_nxt;
  cltpt_pin_t pinState_r;
  cltpt_pin_t pinState_nxt;

  // input synchronisers
  logic capMeta_r;
  logic capSync_r;
  logic cmpInMeta_r;
  logic cmpInSync_r;

  // decoded controls
  logic unitOn;
  logic run4;
  logic run5;
  logic tick5;
  logic ovf5;
  logic tick4;
  logic matchA;
  logic matchB;
  logic clear4;
  logic wrCnt4;
  logic wrCnt5;
  logic pwm1;
  logic captureIn;
  logic wrRun;
  logic wrPinSel;
  logic wrHalt;
  logic wrCcr4;
  logic wrMode4;
  logic wrOcr4;
  logic wrCcr5;
  logic wrCmpA4;
  logic wrCmpB4;

  // control fields pulled out of the configuration registers
  logic [2:0] clrField4;
  logic [1:0] edgeField4;
  logic [2:0] pscField4;
  logic [2:0] clrField5;
  logic [1:0] edgeField5;
  logic [2:0] pscField5;
  logic [3:0] modeField4;
  logic [3:0] aField4;
  logic [3:0] bField4;

  assign unitOn = ~haltCtl_r[`CLTPT_BIT_HALT];
  assign run4 = unitOn & runCtl_r[`CLTPT_BIT_RUN4];
  assign run5 = unitOn & runCtl_r[`CLTPT_BIT_RUN5];
  assign pwm1 = (modeField4 == `CLTPT_MODE_PWM1);
  // counters only accept full-width accesses
  assign wrCnt4 = regWrStb & regWide & (regAddr == `CLTPT_ADDR_CNT4);
  assign wrCnt5 = regWrStb & regWide & (regAddr == `CLTPT_ADDR_CNT5);

  // ****************************************
  // register write decode
  // ****************************************
  // 8-bit registers and the halt register take any access width; compare registers refuse narrow writes
  assign wrRun = regWrStb & (regAddr == `CLTPT_ADDR_RUN);
  assign wrPinSel = regWrStb & (regAddr == `CLTPT_ADDR_PFS9);
  assign wrHalt = regWrStb & (regAddr == `CLTPT_ADDR_HALT);
  assign wrCcr4 = regWrStb & (regAddr == `CLTPT_ADDR_CCR4);
  assign wrMode4 = regWrStb & (regAddr == `CLTPT_ADDR_MODE4);
  assign wrOcr4 = regWrStb & (regAddr == `CLTPT_ADDR_OCR4);
  assign wrCcr5 = regWrStb & (regAddr == `CLTPT_ADDR_CCR5);
  assign wrCmpA4 = regWrStb & regWide & (regAddr == `CLTPT_ADDR_CMPA4);
  assign wrCmpB4 = regWrStb & regWide & (regAddr == `CLTPT_ADDR_CMPB4);

  // ****************************************
  // control field extraction
  // ****************************************
  // named fields keep the count and pin logic in step with the register map
  assign clrField4 = ccr4_r[`CLTPT_CLR_HI:`CLTPT_CLR_LO];
  assign edgeField4 = ccr4_r[`CLTPT_EDGE_HI:`CLTPT_EDGE_LO];
  assign pscField4 = ccr4_r[`CLTPT_PSC_HI:`CLTPT_PSC_LO];
  assign clrField5 = ccr5_r[`CLTPT_CLR_HI:`CLTPT_CLR_LO];
  assign edgeField5 = ccr5_r[`CLTPT_EDGE_HI:`CLTPT_EDGE_LO];
  assign pscField5 = ccr5_r[`CLTPT_PSC_HI:`CLTPT_PSC_LO];
  assign modeField4 = mode4_r[`CLTPT_MODE_HI:`CLTPT_MODE_LO];
  assign aField4 = ocr4_r[`CLTPT_IOA_HI:`CLTPT_IOA_LO];
  assign bField4 = ocr4_r[`CLTPT_IOB_HI:`CLTPT_IOB_LO];

  // ****************************************
  // pin input synchronisers
  // ****************************************
  // both pins pass two flops before any logic reads them
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      capMeta_r <= 1'b0;
      capSync_r <= 1'b0;
      cmpInMeta_r <= 1'b0;
      cmpInSync_r <= 1'b0;
    end else begin
      capMeta_r <= capturePortPin;
      capSync_r <= capMeta_r;
      cmpInMeta_r <= comparePortPinIn;
      cmpInSync_r <= cmpInMeta_r;
    end
  end
  // capture source follows the route select; read back only at unmapped read addresses
  assign captureIn = pinSel_r[`CLTPT_BIT_ROUTE] ? capSync_r : cmpInSync_r;

  // ****************************************
  // count clock selection
  // ****************************************
  // module clock counts once per cycle; only direct on ch5, cascade on ch4, and falling edge supported
  // unsupported ch5 clear settings stop that channel rather than count wrongly
  assign tick5 = run5 & (pscField5 == `CLTPT_PSC_DIRECT) &
                 (edgeField5 == `CLTPT_EDGE_FALL) &
                 (clrField5 == `CLTPT_CLR_NONE);
  assign ovf5 = tick5 & (cnt5_r == `CLTPT_CNT_MAX);
  // the overflow pulse is the falling edge of the cascaded count clock
  assign tick4 = run4 & (pscField4 == `CLTPT_PSC_CASCADE) &
                 (edgeField4 == `CLTPT_EDGE_FALL) & ovf5;

  // ****************************************
  // compare matches
  // ****************************************
  assign matchA = run4 & (cnt4_r == cmpA4_r);
  assign matchB = run4 & (cnt4_r == cmpB4_r);
  assign clear4 = matchB & tick4 & (clrField4 == `CLTPT_CLR_CMPB);

  // ****************************************
  // channel five counter
  // ****************************************
  // never cleared by events; clear field other values unsupported
  always_comb begin
    cnt5_nxt = cnt5_r;
    if (wrCnt5) begin
      cnt5_nxt = regWrData;
    end else if (tick5) begin
      cnt5_nxt = cnt5_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt5_r <= `CLTPT_RST_16;
    end else begin
      cnt5_r <= cnt5_nxt;
    end
  end

  // ****************************************
  // channel four counter
  // ****************************************
  // clear on B match happens on the count tick that would pass it
  always_comb begin
    cnt4_nxt = cnt4_r;
    if (wrCnt4) begin
      cnt4_nxt = regWrData;
    end else if (clear4) begin
      cnt4_nxt = `CLTPT_RST_16;
    end else if (tick4) begin
      cnt4_nxt = cnt4_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt4_r <= `CLTPT_RST_16;
    end else begin
      cnt4_r <= cnt4_nxt;
    end
  end

  // ****************************************
  // pwm output state
  // ****************************************
  // stopped channel shows the low initial level whatever the A field holds
  always_comb begin
    pinState_nxt = pinState_r;
    if (!run4) begin
      pinState_nxt = CLTPT_PIN_LOW;
    end else if (pwm1) begin
      case (pinState_r)
        CLTPT_PIN_LOW: begin
          if (matchA && aField4 == `CLTPT_IOA_HIGH) begin
            pinState_nxt = CLTPT_PIN_HIGH;
          end
        end
        CLTPT_PIN_HIGH: begin
          if (matchB && bField4 == `CLTPT_IOB_LOW) begin
            pinState_nxt = CLTPT_PIN_LOW;
          end
        end
        default: begin
          pinState_nxt = CLTPT_PIN_LOW;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pinState_r <= CLTPT_PIN_LOW;
    end else begin
      pinState_r <= pinState_nxt;
    end
  end

  // pin outputs; drive only while the unit is released
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      comparePortPin_r <= 1'b0;
      comparePortPinOe_n_r <= 1'b1;
      captureSel_r <= 1'b0;
    end else begin
      comparePortPin_r <= (pinState_nxt == CLTPT_PIN_HIGH);
      comparePortPinOe_n_r <= ~(unitOn & pwm1);
      captureSel_r <= pinSel_r[`CLTPT_BIT_ROUTE];
    end
  end

  // ****************************************
  // control register writes
  // ****************************************
  // software keeps to reconfiguring stopped channels only
  // start bits; the two unused top bits always read back as zero
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      runCtl_r <= `CLTPT_RST_8;
    end else if (wrRun) begin
      runCtl_r <= {2'b00, regWrData[`CLTPT_RUN_HI:`CLTPT_RUN_LO]};
    end
  end

  // pin route select; only the route bit has an effect here
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pinSel_r <= `CLTPT_RST_8;
    end else if (wrPinSel) begin
      pinSel_r <= regWrData[7:0];
    end
  end

  // module halt; comes out of reset halted so the pin is not driven early
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      haltCtl_r <= `CLTPT_RST_HALT;
    end else if (wrHalt) begin
      haltCtl_r <= regWrData;
    end
  end

  // channel four configuration: count control, mode and output control
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ccr4_r <= `CLTPT_RST_8;
      mode4_r <= `CLTPT_RST_8;
      ocr4_r <= `CLTPT_RST_8;
    end else begin
      if (wrCcr4) begin
        ccr4_r <= regWrData[7:0];
      end
      if (wrMode4) begin
        mode4_r <= regWrData[7:0];
      end
      if (wrOcr4) begin
        ocr4_r <= regWrData[7:0];
      end
    end
  end

  // channel five count control
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ccr5_r <= `CLTPT_RST_8;
    end else if (wrCcr5) begin
      ccr5_r <= regWrData[7:0];
    end
  end

  // compare registers accept only full-width writes
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cmpA4_r <= `CLTPT_RST_16;
      cmpB4_r <= `CLTPT_RST_16;
    end else begin
      if (wrCmpA4) begin
        cmpA4_r <= regWrData;
      end
      if (wrCmpB4) begin
        cmpB4_r <= regWrData;
      end
    end
  end

  // ****************************************
  // read port
  // ****************************************
  // data valid only the cycle after the strobe; narrow reads of counters and compare regs give zero
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData_r <= `CLTPT_RST_16;
    end else if (regRdStb) begin
      case (regAddr)
        `CLTPT_ADDR_RUN: regRdData_r <= {8'h00, runCtl_r};
        `CLTPT_ADDR_PFS9: regRdData_r <= {8'h00, pinSel_r};
        `CLTPT_ADDR_HALT: regRdData_r <= haltCtl_r;
        `CLTPT_ADDR_CCR4: regRdData_r <= {8'h00, ccr4_r};
        `CLTPT_ADDR_MODE4: regRdData_r <= {8'h00, mode4_r};
        `CLTPT_ADDR_OCR4: regRdData_r <= {8'h00, ocr4_r};
        `CLTPT_ADDR_CCR5: regRdData_r <= {8'h00, ccr5_r};
        `CLTPT_ADDR_CNT4: regRdData_r <= regWide ? cnt4_r : 16'h0000;
        `CLTPT_ADDR_CNT5: regRdData_r <= regWide ? cnt5_r : 16'h0000;
        `CLTPT_ADDR_CMPA4: regRdData_r <= regWide ? cmpA4_r : 16'h0000;
        `CLTPT_ADDR_CMPB4: regRdData_r <= regWide ? cmpB4_r : 16'h0000;
        default: regRdData_r <= {15'h0000, captureIn};
      endcase
    end else begin
      regRdData_r <= `CLTPT_RST_16;
    end
  end

endmodule

/* File: verif/cltpt_chk.sv */
// port checker for the cascaded pulse timer
// assumes the bind below and the defs header on the include path
`timescale 1ns/1ns
`include "cltpt_defs.svh"
module cltpt_chk
  import cltpt_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [27:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic regWide,
  input wire logic [15:0] regRdData_r,
  // pins
  input wire logic comparePortPin_r,
  input wire logic comparePortPinOe_n_r,
  input wire logic captureSel_r
);
  // *************************************
  // register port and pin relations
  // *************************************
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // write then immediate readback of compare A
  sequence sWrA;
    regWrStb && regWide && regAddr == `CLTPT_ADDR_CMPA4;
  endsequence
  sequence sRdA;
    regRdStb && regWide && regAddr == `CLTPT_ADDR_CMPA4;
  endsequence
  AST_WR_RD: assert property (sWrA ##1 sRdA |=> regRdData_r == $past(regWrData, 2))
    else $error("compare A readback differs from write");
  AST_RD_IDLE: assert property (!regRdStb |=> regRdData_r == 16'h0000)
    else $error("read data not zero outside read slot");
  AST_NARROW: assert property (regRdStb && !regWide && (regAddr == `CLTPT_ADDR_CMPA4
    || regAddr == `CLTPT_ADDR_CNT4) |=> regRdData_r == 16'h0000)
    else $error("narrow read not refused");
  // route select reaches its output two edges after the write
  AST_ROUTE: assert property (regWrStb && regAddr == `CLTPT_ADDR_PFS9
    |-> ##2 captureSel_r == $past(regWrData[6], 2))
    else $error("route select not taken from bit 6");
  AST_ROUTE_HOLD: assert property (!(regWrStb && regAddr == `CLTPT_ADDR_PFS9)
    |-> ##2 $stable(captureSel_r))
    else $error("route select moved without a write");
  // stopping must fall back to the initial low level
  AST_PIN_STOP: assert property (regWrStb && regAddr == `CLTPT_ADDR_RUN && !regWrData[4]
    |-> ##[1:2] !comparePortPin_r)
    else $error("pin not low after stop");
  AST_OE_HALT: assert property (regWrStb && regAddr == `CLTPT_ADDR_HALT && regWrData[0]
    |-> ##[1:2] comparePortPinOe_n_r)
    else $error("pin still driven while halted");
  AST_OE_MODE: assert property (regWrStb && regAddr == `CLTPT_ADDR_MODE4
    && regWrData[3:0] != `CLTPT_MODE_PWM1 |-> ##[1:2] comparePortPinOe_n_r)
    else $error("pin driven outside pwm mode one");
endmodule

bind cltpt_timer cltpt_chk u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWrStb(regWrStb), .regRdStb(regRdStb), .regWide(regWide), .regRdData_r(regRdData_r),
  .comparePortPin_r(comparePortPin_r), .comparePortPinOe_n_r(comparePortPinOe_n_r),
  .captureSel_r(captureSel_r)
);

/* File: verif/cltpt_pin_model.sv */
// external circuit on the pulse pin and the capture pin
// assumes the timer clock; no pull on the pulse pin
`timescale 1ns/1ns
module cltpt_pin_model (
  // clock
  input wire logic clk_sys,
  // pulse pin from the timer
  input wire logic pinOut,
  input wire logic pinOe_n,
  // capture level wanted by the bench
  input wire logic capDrive,
  output logic pinLevel,
  output logic capLevel
);
  logic lastLevel_r = 1'b0;
  // remember last driven level; released wire shows its inverse, never a stale copy
  always @(posedge clk_sys) begin
    if (!pinOe_n) begin
      lastLevel_r <= pinOut;
    end
  end
  assign pinLevel = pinOe_n ? !lastLevel_r : pinOut;
  assign capLevel = capDrive;
endmodule

/* File: verif/tb_cltpt_timer.sv */
// self-checking bench for the cascaded pulse timer
// assumes design, checker and pin model compiled before it
`timescale 1ns/1ns
`include "cltpt_defs.svh"
module tb_cltpt_timer;
  localparam logic [15:0] START = 16'hfff0;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [27:0] regAddr = 28'h000_0000;
  logic [15:0] regWrData = 16'h0000;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic regWide = 1'b1;
  logic capDrive = 1'b0;
  logic [15:0] regRdData_r;
  logic capLevel, pinLevel, comparePortPin_r, comparePortPinOe_n_r, captureSel_r;
  int miscompares = 0;
  int checked = 0;
  int n;
  logic [15:0] v;
  always #25 clk_sys = !clk_sys;
  cltpt_timer u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regWide(regWide), .regRdData_r(regRdData_r),
    .capturePortPin(capLevel), .comparePortPinIn(pinLevel), .comparePortPin_r(comparePortPin_r),
    .comparePortPinOe_n_r(comparePortPinOe_n_r), .captureSel_r(captureSel_r));
  cltpt_pin_model u_pin (.clk_sys(clk_sys), .pinOut(comparePortPin_r),
    .pinOe_n(comparePortPinOe_n_r), .capDrive(capDrive), .pinLevel(pinLevel), .capLevel(capLevel));
  // *************************************
  // bus tasks and comparison
  // *************************************
  task automatic bus(input logic w, input logic [27:0] a, input logic [15:0] d, input logic wd);
    @(posedge clk_sys);
    regWrStb <= w;
    regRdStb <= !w;
    regAddr <= a;
    regWrData <= d;
    regWide <= wd;
  endtask
  // idle cycles; ends mid-cycle so outputs are settled
  task automatic cyc(input int k);
    repeat (k) begin
      @(posedge clk_sys);
      regWrStb <= 1'b0;
      regRdStb <= 1'b0;
    end
    @(negedge clk_sys);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [27:0] a, input logic [15:0] d);
    bus(1'b1, a, d, 1'b1);
  endtask
  task automatic rd(input logic [27:0] a, input logic wd, input logic [15:0] e);
    bus(1'b0, a, 16'h0000, wd);
    cyc(1);
    chk(regRdData_r, e);
  endtask
  // channels reconfigured only while stopped
  task automatic restart();
    wr(`CLTPT_ADDR_RUN, 16'h0000);
    wr(`CLTPT_ADDR_CNT5, START);
    wr(`CLTPT_ADDR_RUN, 16'h0030);
    cyc(1);
  endtask
  task automatic waitPin(input logic lv, output int c);
    c = 0;
    while (comparePortPin_r !== lv && c < 200) begin
      @(negedge clk_sys);
      c++;
    end
  endtask
  // cycles until the lower channel wraps, with a few cycles of pipeline slack
  function automatic logic [15:0] span(input int c);
    int w;
    w = 32'h0001_0000 - int'(START);
    return (c >= w - 4 && c <= w + 4) ? 16'h0001 : 16'h0000;
  endfunction
  task automatic stop_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    stop_test();
  end
  // *************************************
  // tests
  // *************************************
  initial begin
    void'($urandom(72));
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(`CLTPT_ADDR_HALT, 1'b1, `CLTPT_RST_HALT);
    rd(`CLTPT_ADDR_CNT4, 1'b1, `CLTPT_RST_16);
    rd(`CLTPT_ADDR_CNT5, 1'b1, `CLTPT_RST_16);
    chk({15'h0000, comparePortPinOe_n_r}, 16'h0001);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
      wr(`CLTPT_ADDR_CMPA4, v);
      rd(`CLTPT_ADDR_CMPA4, 1'b1, v);
      wr(`CLTPT_ADDR_CNT4, ~v);
      rd(`CLTPT_ADDR_CNT4, 1'b1, ~v);
      bus(1'b1, `CLTPT_ADDR_CMPA4, 16'h5a5a, 1'b0);
      rd(`CLTPT_ADDR_CMPA4, 1'b0, 16'h0000);
      rd(`CLTPT_ADDR_CMPA4, 1'b1, v);
    end
    $display("test registers done");
    wr(`CLTPT_ADDR_PFS9, 16'h0040);
    cyc(2);
    chk({15'h0000, captureSel_r}, 16'h0001);
    @(posedge clk_sys);
    capDrive <= 1'b1;
    cyc(4);
    rd(28'h000_1000, 1'b1, 16'h0001);
    @(posedge clk_sys);
    capDrive <= 1'b0;
    cyc(4);
    rd(28'h000_1000, 1'b1, 16'h0000);
    wr(`CLTPT_ADDR_PFS9, 16'h0000);
    cyc(2);
    chk({15'h0000, captureSel_r}, 16'h0000);
    // released pulse pin, never driven yet, shows the inverse of the model's initial low level
    rd(28'h000_1000, 1'b1, 16'h0001);
    $display("test route done");
    wr(`CLTPT_ADDR_HALT, 16'h0000);
    wr(`CLTPT_ADDR_CCR5, 16'h0000);
    wr(`CLTPT_ADDR_CCR4, 16'h0047);
    wr(`CLTPT_ADDR_MODE4, 16'h0002);
    wr(`CLTPT_ADDR_OCR4, 16'h0052);
    wr(`CLTPT_ADDR_CMPA4, 16'h0001);
    wr(`CLTPT_ADDR_CMPB4, 16'h0002);
    wr(`CLTPT_ADDR_CNT4, 16'h0000);
    cyc(2);
    chk({15'h0000, comparePortPinOe_n_r}, 16'h0000);
    chk({15'h0000, comparePortPin_r}, 16'h0000);
    restart();
    waitPin(1'b1, n);
    chk(span(n), 16'h0001);
    rd(`CLTPT_ADDR_CNT4, 1'b1, 16'h0001);
    wr(`CLTPT_ADDR_RUN, 16'h0000);
    cyc(2);
    chk({15'h0000, comparePortPin_r}, 16'h0000);
    bus(1'b0, `CLTPT_ADDR_CNT5, 16'h0000, 1'b1);
    cyc(1);
    v = regRdData_r;
    rd(`CLTPT_ADDR_CNT5, 1'b1, v);
    wr(`CLTPT_ADDR_HALT, 16'h0001);
    cyc(2);
    chk({15'h0000, comparePortPinOe_n_r}, 16'h0001);
    wr(`CLTPT_ADDR_HALT, 16'h0000);
    restart();
    waitPin(1'b1, n);
    chk((n < 4) ? 16'h0001 : 16'h0000, 16'h0001);
    waitPin(1'b0, n);
    chk(span(n), 16'h0001);
    rd(`CLTPT_ADDR_CNT4, 1'b1, 16'h0002);
    restart();
    cyc(24);
    rd(`CLTPT_ADDR_CNT4, 1'b1, 16'h0000);
    chk({15'h0000, comparePortPin_r}, 16'h0000);
    wr(`CLTPT_ADDR_RUN, 16'h0000);
    wr(`CLTPT_ADDR_MODE4, 16'h0000);
    cyc(2);
    chk({15'h0000, comparePortPinOe_n_r}, 16'h0001);
    $display("test cascade done");
    stop_test();
  end
endmodule
